// >>> design/adpm_defs.svh
// offsets, fields, reset values and counts of the pin mux and strap block
`ifndef ADPM_DEFS_SVH
`define ADPM_DEFS_SVH
`define ADPM_OFF_SYS_CTRL  8'h00
`define ADPM_OFF_FLAG_OUT  8'h04
`define ADPM_OFF_FLAG_OE   8'h08
`define ADPM_OFF_FLAG_IN   8'h0C
`define ADPM_OFF_STATUS    8'h10
`define ADPM_OFF_PP_ADDR   8'h14
`define ADPM_OFF_PP_WDATA  8'h18
`define ADPM_OFF_PP_CMD    8'h1C
`define ADPM_OFF_RATIO     8'h20
`define ADPM_CTRL_PP_EN    0
`define ADPM_CTRL_WIDE     1
`define ADPM_CTRL_FLAGS    20
`define ADPM_CTRL_RST      32'h0000_0000
`define ADPM_STRAP_CYC     13'h0002
`define ADPM_RATIO_3       5'h03
`define ADPM_RATIO_16      5'h10
`define ADPM_RATIO_8       5'h08
`define ADPM_RATIO_NONE    5'h00
`define ADPM_PLL_LOCK_CYC  13'h1000
`define ADPM_STROBE_CYC    3'h4
`endif

// >>> design/adpm_pkg.sv
// types of the pin mux and strap block
package adpm_pkg;
  typedef enum logic [1:0] {
    ADPM_IDLE = 2'b00,
    ADPM_ALE  = 2'b01,
    ADPM_DATA = 2'b11,
    ADPM_DONE = 2'b10
  } adpm_state_t;

  typedef enum logic [1:0] {
    ADPM_BOOT_SPI_SLAVE  = 2'b00,
    ADPM_BOOT_SPI_MASTER = 2'b01,
    ADPM_BOOT_PARALLEL   = 2'b10,
    ADPM_BOOT_INTERNAL   = 2'b11
  } adpm_boot_t;

  typedef struct packed {
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic [15:0] ad;
    logic [15:0] ad_oe;
  } adpm_pins_t;
endpackage

// >>> design/adpm_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module adpm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// >>> design/adpm_top.sv
// address/data pin mux, flag mapping, strap decode and parallel port sequencer
`timescale 1ns/1ps
`include "adpm_defs.svh"
// Operation
// - pins act as flags only when control bit 20 set and parallel port off
// - pins 0..7 carry flags 8..15, pins 8..15 carry flags 0..7
// - boot straps: 00 spi slave, 01 spi master, 10 parallel eprom, 11 rom
// - ratio straps: 00 3:1, 01 16:1, 10 8:1, 11 reserved
// - 8-bit: ale phase A15-8 low, A23-16 high; then D7-0 low, A7-0 high
// - 16-bit: ale phase A15-0; then D15-0
// - read, write and latch strobes always driven, never high impedance
// - start-up ratio from straps; software may change it once the core runs
// - core starts 4096 input clock cycles after reset release
module adpm_top (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic [15:0]       addr_data_pins_i,
  input  wire logic [1:0]        boot_select_straps_i,
  input  wire logic [1:0]        clock_ratio_straps_i,
  output adpm_pkg::adpm_pins_t   pins_o,
  output adpm_pkg::adpm_boot_t   boot_mode_o,
  output logic      [4:0]        core_ratio_o,
  output logic                   core_run_o
);
  logic [15:0] ad_s;
  logic [3:0]  straps_s;

  adpm_sync #(.W(16)) u_sync_ad (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (addr_data_pins_i),
    .q_o   (ad_s)
  );

  adpm_sync #(.W(4)) u_sync_strap (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({boot_select_straps_i, clock_ratio_straps_i}),
    .q_o   (straps_s)
  );

  logic [31:0]           sys_ctrl_q, sys_ctrl_d;
  logic [15:0]           flag_out_q, flag_out_d;
  logic [15:0]           flag_oe_q, flag_oe_d;
  logic [15:0]           flag_in_q, flag_in_d;
  logic [23:0]           pp_addr_q, pp_addr_d;
  logic [15:0]           pp_wdata_q, pp_wdata_d;
  logic [15:0]           pp_rdata_q, pp_rdata_d;
  logic [4:0]            ratio_q, ratio_d;
  logic                  ratio_rsvd_q, ratio_rsvd_d;
  adpm_pkg::adpm_boot_t  boot_q, boot_d;
  logic                  strap_done_q, strap_done_d;
  logic [12:0]           lock_cnt_q, lock_cnt_d;
  logic                  locked_q, locked_d;
  adpm_pkg::adpm_state_t st_q, st_d;
  logic                  is_read_q, is_read_d;
  logic [2:0]            strb_cnt_q, strb_cnt_d;
  logic                  ack_q, ack_d;
  logic [31:0]           dat_q, dat_d;
  adpm_pkg::adpm_pins_t  pins_q, pins_d;

  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic        flag_mode;
  logic        wide;
  logic        start_wr;
  logic        start_rd;

  assign req       = cyc_i & stb_i & ~ack_q;
  assign wr        = req & we_i;
  assign wmask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  // parallel port enable has priority: flags only with the port off
  assign flag_mode = sys_ctrl_q[`ADPM_CTRL_FLAGS] & ~sys_ctrl_q[`ADPM_CTRL_PP_EN];
  assign wide      = sys_ctrl_q[`ADPM_CTRL_WIDE];
  // cycles start only with the port on, the core running and the sequencer idle
  assign start_wr  = wr & (adr_i == `ADPM_OFF_PP_WDATA) & sel_i[0];
  assign start_rd  = wr & (adr_i == `ADPM_OFF_PP_CMD) & sel_i[0] & dat_i[0];

  // straps and clock ratio
  always_comb begin
    strap_done_d = strap_done_q;
    boot_d       = boot_q;
    ratio_d      = ratio_q;
    ratio_rsvd_d = ratio_rsvd_q;
    lock_cnt_d   = lock_cnt_q;
    locked_d     = locked_q;
    if (!strap_done_q) begin
      // waits until the synchroniser has flushed its reset zeros
      if (lock_cnt_q == `ADPM_STRAP_CYC) begin
        strap_done_d = 1'b1;
        boot_d       = adpm_pkg::adpm_boot_t'(straps_s[3:2]);
        ratio_rsvd_d = 1'b0;
        case (straps_s[1:0])
          2'b00:   ratio_d = `ADPM_RATIO_3;
          2'b01:   ratio_d = `ADPM_RATIO_16;
          2'b10:   ratio_d = `ADPM_RATIO_8;
          default: begin
            ratio_d      = `ADPM_RATIO_NONE;
            ratio_rsvd_d = 1'b1;
          end
        endcase
      end
    end else if (wr && adr_i == `ADPM_OFF_RATIO && sel_i[0] && locked_q) begin
      ratio_d      = dat_i[4:0];
      ratio_rsvd_d = 1'b0;
    end
    if (!locked_q) begin
      lock_cnt_d = lock_cnt_q + 13'h0001;
      locked_d   = (lock_cnt_d == `ADPM_PLL_LOCK_CYC);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_q <= 1'b0;
      boot_q       <= adpm_pkg::ADPM_BOOT_SPI_SLAVE;
      ratio_q      <= `ADPM_RATIO_NONE;
      ratio_rsvd_q <= 1'b0;
      lock_cnt_q   <= 13'h0000;
      locked_q     <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
      boot_q       <= boot_d;
      ratio_q      <= ratio_d;
      ratio_rsvd_q <= ratio_rsvd_d;
      lock_cnt_q   <= lock_cnt_d;
      locked_q     <= locked_d;
    end
  end

  // register file and bus answer
  always_comb begin
    sys_ctrl_d = sys_ctrl_q;
    flag_out_d = flag_out_q;
    flag_oe_d  = flag_oe_q;
    pp_addr_d  = pp_addr_q;
    pp_wdata_d = pp_wdata_q;
    // flag inputs mirror the pin halves swapped
    flag_in_d  = {ad_s[7:0], ad_s[15:8]};
    ack_d      = req;
    dat_d      = 32'h0000_0000;
    if (wr) begin
      case (adr_i)
        `ADPM_OFF_SYS_CTRL: sys_ctrl_d = (sys_ctrl_q & ~wmask) | (dat_i & wmask);
        `ADPM_OFF_FLAG_OUT: flag_out_d = (flag_out_q & ~wmask[15:0])
                                       | (dat_i[15:0] & wmask[15:0]);
        `ADPM_OFF_FLAG_OE:  flag_oe_d = (flag_oe_q & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
        `ADPM_OFF_PP_ADDR:  pp_addr_d = (pp_addr_q & ~wmask[23:0]) | (dat_i[23:0] & wmask[23:0]);
        `ADPM_OFF_PP_WDATA: pp_wdata_d = (pp_wdata_q & ~wmask[15:0])
                                       | (dat_i[15:0] & wmask[15:0]);
        default:            sys_ctrl_d = sys_ctrl_q;
      endcase
    end
    if (req && !we_i) begin
      case (adr_i)
        `ADPM_OFF_SYS_CTRL: dat_d = sys_ctrl_q;
        `ADPM_OFF_FLAG_OUT: dat_d = {16'h0000, flag_out_q};
        `ADPM_OFF_FLAG_OE:  dat_d = {16'h0000, flag_oe_q};
        `ADPM_OFF_FLAG_IN:  dat_d = {16'h0000, flag_in_q};
        `ADPM_OFF_STATUS:   dat_d = {24'h00_0000, locked_q, (st_q != adpm_pkg::ADPM_IDLE),
                                     ratio_rsvd_q, boot_q, straps_s[1:0], 1'b0};
        `ADPM_OFF_PP_ADDR:  dat_d = {8'h00, pp_addr_q};
        `ADPM_OFF_PP_WDATA: dat_d = {16'h0000, pp_wdata_q};
        `ADPM_OFF_PP_CMD:   dat_d = {16'h0000, pp_rdata_q};
        `ADPM_OFF_RATIO:    dat_d = {27'h000_0000, ratio_q};
        default:            dat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_ctrl_q <= `ADPM_CTRL_RST;
      flag_out_q <= 16'h0000;
      flag_oe_q  <= 16'h0000;
      flag_in_q  <= 16'h0000;
      pp_addr_q  <= 24'h00_0000;
      pp_wdata_q <= 16'h0000;
      ack_q      <= 1'b0;
      dat_q      <= 32'h0000_0000;
    end else begin
      sys_ctrl_q <= sys_ctrl_d;
      flag_out_q <= flag_out_d;
      flag_oe_q  <= flag_oe_d;
      flag_in_q  <= flag_in_d;
      pp_addr_q  <= pp_addr_d;
      pp_wdata_q <= pp_wdata_d;
      ack_q      <= ack_d;
      dat_q      <= dat_d;
    end
  end

  // parallel port sequencer and pin drive
  always_comb begin
    st_d       = st_q;
    is_read_d  = is_read_q;
    strb_cnt_d = strb_cnt_q;
    pp_rdata_d = pp_rdata_q;
    pins_d.ale   = 1'b0;
    pins_d.rd_n  = 1'b1;
    pins_d.wr_n  = 1'b1;
    pins_d.ad    = 16'h0000;
    pins_d.ad_oe = 16'h0000;
    case (st_q)
      adpm_pkg::ADPM_IDLE: begin
        if ((start_wr || start_rd) && sys_ctrl_q[`ADPM_CTRL_PP_EN] && locked_q) begin
          st_d      = adpm_pkg::ADPM_ALE;
          is_read_d = start_rd;
        end
      end
      adpm_pkg::ADPM_ALE: begin
        st_d       = adpm_pkg::ADPM_DATA;
        strb_cnt_d = `ADPM_STROBE_CYC;
      end
      adpm_pkg::ADPM_DATA: begin
        strb_cnt_d = strb_cnt_q - 3'h1;
        if (strb_cnt_q == 3'h1) begin
          st_d = adpm_pkg::ADPM_DONE;
          // sampled late in the strobe to cover the two-stage input path
          if (is_read_q) begin
            pp_rdata_d = wide ? ad_s : {8'h00, ad_s[7:0]};
          end
        end
      end
      adpm_pkg::ADPM_DONE: st_d = adpm_pkg::ADPM_IDLE;
      default:             st_d = adpm_pkg::ADPM_IDLE;
    endcase
    // pin values for the coming cycle, from the next state
    if (flag_mode) begin
      pins_d.ad    = {flag_out_q[7:0], flag_out_q[15:8]};
      pins_d.ad_oe = {flag_oe_q[7:0], flag_oe_q[15:8]};
    end else if (st_d == adpm_pkg::ADPM_ALE) begin
      pins_d.ale   = 1'b1;
      pins_d.ad_oe = 16'hFFFF;
      pins_d.ad    = wide ? pp_addr_q[15:0] : pp_addr_q[23:8];
    end else if (st_d == adpm_pkg::ADPM_DATA) begin
      pins_d.rd_n  = ~is_read_d;
      pins_d.wr_n  = is_read_d;
      if (wide) begin
        pins_d.ad    = pp_wdata_q;
        pins_d.ad_oe = is_read_d ? 16'h0000 : 16'hFFFF;
      end else begin
        pins_d.ad    = {pp_addr_q[7:0], pp_wdata_q[7:0]};
        pins_d.ad_oe = is_read_d ? 16'hFF00 : 16'hFFFF;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= adpm_pkg::ADPM_IDLE;
      is_read_q    <= 1'b0;
      strb_cnt_q   <= 3'h0;
      pp_rdata_q   <= 16'h0000;
      pins_q.ale   <= 1'b0;
      pins_q.rd_n  <= 1'b1;
      pins_q.wr_n  <= 1'b1;
      pins_q.ad    <= 16'h0000;
      pins_q.ad_oe <= 16'h0000;
    end else begin
      st_q       <= st_d;
      is_read_q  <= is_read_d;
      strb_cnt_q <= strb_cnt_d;
      pp_rdata_q <= pp_rdata_d;
      pins_q     <= pins_d;
    end
  end

  assign pins_o       = pins_q;
  assign boot_mode_o  = boot_q;
  assign core_ratio_o = ratio_q;
  assign core_run_o   = locked_q;
  assign ack_o        = ack_q;
  assign dat_o        = dat_q;
endmodule

// >>> test/adpm_assertions.sv
// port assertions of the pin mux and strap block
`timescale 1ns/1ps
module adpm_assertions (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           cyc_i,
  input wire logic           stb_i,
  input wire logic           ack_o,
  input adpm_pkg::adpm_pins_t pins_o,
  input wire logic [4:0]     core_ratio_o,
  input wire logic           core_run_o
);
  logic [12:0] cnt_q;
  logic [12:0] cnt_d;
  // saturates so a long run never wraps into a false lock window
  always_comb cnt_d = (&cnt_q) ? cnt_q : cnt_q + 13'h0001;
  always_ff @(posedge clk_i) cnt_q <= rst_i ? 13'h0000 : cnt_d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_strb_excl; pins_o.rd_n || pins_o.wr_n; endproperty
  a_strb_excl: assert property (p_strb_excl) else $error("both strobes low");
  property p_ale_one;
    $rose(pins_o.ale) |=> !pins_o.ale && !(pins_o.rd_n && pins_o.wr_n);
  endproperty
  a_ale_one: assert property (p_ale_one) else $error("no strobe after ale");
  property p_strobe_len;
    $fell(pins_o.rd_n && pins_o.wr_n) |->
      !(pins_o.rd_n && pins_o.wr_n) [*4] ##1 (pins_o.rd_n && pins_o.wr_n);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
  property p_ale_drive; pins_o.ale |-> pins_o.ad_oe == 16'hFFFF; endproperty
  a_ale_drive: assert property (p_ale_drive) else $error("address undriven");
  property p_ale_run; pins_o.ale |-> core_run_o; endproperty
  a_ale_run: assert property (p_ale_run) else $error("port before lock");
  property p_lock;
    $rose(core_run_o) |-> cnt_q >= 13'h0FFF && cnt_q <= 13'h1001;
  endproperty
  a_lock: assert property (p_lock) else $error("lock wait length");
  // software may set any ratio once running, so only the start-up value is tabled
  property p_ratio;
    !core_run_o |-> core_ratio_o inside {5'h03, 5'h10, 5'h08, 5'h00};
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio out of table");
  c_ale: cover property ($rose(pins_o.ale));
  c_run: cover property ($rose(core_run_o));
  c_rd: cover property ($fell(pins_o.rd_n));
endmodule

// >>> test/adpm_mem_model.sv
// external address latch and parallel boot memory model
`timescale 1ns/1ps
module adpm_mem_model (
  input  wire logic           clk_i,
  input  adpm_pkg::adpm_pins_t pins_i,
  input  wire logic [15:0]    ext_i,
  output logic      [15:0]    level_o,
  output logic      [15:0]    wr_o
);
  logic [15:0] latch_q;
  logic [15:0] drv;
  // memory answers only under read strobe, else the bench line or pull-up
  always_comb begin
    drv = pins_i.rd_n ? ext_i : ~latch_q;
    level_o = (pins_i.ad & pins_i.ad_oe) | (drv & ~pins_i.ad_oe);
  end
  always_ff @(posedge clk_i) begin
    if (pins_i.ale) latch_q <= pins_i.ad;
    if (!pins_i.wr_n) wr_o <= level_o;
  end
endmodule

// >>> test/tb_top.sv
// testbench of the pin mux and strap block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
  logic        ack_o, core_run_o;
  logic [15:0] lvl, ext = 16'hFFFF, wr_o;
  logic [1:0]  boot_s = 2'b00, clk_s = 2'b00;
  logic [4:0]  core_ratio_o;
  logic [4:0]  rt [4] = '{5'h03, 5'h10, 5'h08, 5'h00};
  adpm_pkg::adpm_pins_t pins_o;
  adpm_pkg::adpm_boot_t boot_mode_o;
  int bad_count = 0, n_checks = 0, n = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) n <= rst_i ? 0 : n + 1;
  adpm_top adpm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .addr_data_pins_i(lvl), .boot_select_straps_i(boot_s), .clock_ratio_straps_i(clk_s),
    .pins_o(pins_o), .boot_mode_o(boot_mode_o), .core_ratio_o(core_ratio_o),
    .core_run_o(core_run_o));
  adpm_mem_model adpm_mem_model_inst (.clk_i(clk_i), .pins_i(pins_o), .ext_i(ext),
    .level_o(lvl), .wr_o(wr_o));
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // no limit of its own: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot_s <= i[1:0];
      clk_s <= i[1:0];
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(boot_mode_o, i);
      check(core_ratio_o, rt[i]);
    end
    boot_s <= 2'b10;
    clk_s <= 2'b10;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check({pins_o.rd_n, pins_o.wr_n, pins_o.ale}, 3'h6);
    wb(1'b1, 8'h20, 32'h0000_0005);
    wb(1'b0, 8'h20, 32'h0000_0000);
    check(rd, 32'h0000_0008);
    for (int k = 0; k < 5000 && core_run_o !== 1'b1; k++) @(posedge clk_i);
    check(n, 4096);
    wb(1'b1, 8'h20, 32'h0000_0005);
    wb(1'b0, 8'h20, 32'h0000_0000);
    check(rd, 32'h0000_0005);
    check(core_ratio_o, 5'h05);
    wb(1'b0, 8'h3C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    wb(1'b1, 8'h04, 32'h0000_1234);
    wb(1'b1, 8'h08, 32'h0000_F00F);
    wb(1'b1, 8'h00, 32'h0010_0000);
    ext <= 16'hABCD;
    repeat (6) @(posedge clk_i);
    check(pins_o.ad, 16'h3412);
    check(pins_o.ad_oe, 16'h0FF0);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    check(rd, 32'h0000_1DA4);
    ext <= 16'hFFFF;
    wb(1'b1, 8'h00, 32'h0010_0001);
    repeat (2) @(posedge clk_i);
    check(pins_o.ad_oe, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h00, {30'h0, i[1], 1'b1});
      wb(1'b1, 8'h14, 32'h0012_3456);
      wb(1'b1, i[0] ? 8'h1C : 8'h18, i[0] ? 32'h0000_0001 : 32'h0000_9ABC);
      for (int k = 0; k < 20 && pins_o.ale !== 1'b1; k++) @(posedge clk_i);
      check(pins_o.ad, i[1] ? 16'h3456 : 16'h1234);
      @(posedge clk_i);
      if (i[0]) check(pins_o.ad_oe, i[1] ? 16'h0000 : 16'hFF00);
      else check(pins_o.ad, i[1] ? 16'h9ABC : 16'h56BC);
      repeat (8) @(posedge clk_i);
      if (i[0]) begin
        wb(1'b0, 8'h1C, 32'h0000_0000);
        check(rd, i[1] ? 32'h0000_CBA9 : 32'h0000_00CB);
      end
      else check(wr_o, i[1] ? 16'h9ABC : 16'h56BC);
    end
    report_and_stop();
  end
endmodule
bind adpm_top adpm_assertions adpm_assertions_inst (.*);
